// File: core/wdt_pkg.sv
// Constants, register map and carrier types of the watchdog unit
package watchdog_pkg;

  // Timing of the base period
  localparam int unsigned CORE_CLK_HZ    = 125_000_000;
  localparam int unsigned BASE_PERIOD_MS = 4;
  localparam int unsigned BASE_CYCLES    = BASE_PERIOD_MS * (CORE_CLK_HZ / 1000);

  // Postscaler, tap select and frequency select widths
  localparam int unsigned POST_WIDTH = 16;
  localparam int unsigned SEL_WIDTH  = 4;
  localparam int unsigned FREQ_WIDTH = 3;

  // Register byte offsets on the 4-bit Avalon address
  localparam logic [3:0] OFS_CONTROL = 4'h0;
  localparam logic [3:0] OFS_STATUS  = 4'h4;
  localparam logic [3:0] OFS_IRQ_EN  = 4'h8;
  localparam logic [3:0] OFS_CLEAR   = 4'hC;

  // Field positions and reset values
  localparam int unsigned CTRL_SW_EN_BIT   = 0;
  localparam int unsigned STAT_TIMEOUT_BIT = 0;
  localparam int unsigned STAT_CLKFAIL_BIT = 1;
  localparam int unsigned STAT_WIDTH       = 2;
  localparam logic        SW_EN_RESET      = 1'b0;
  localparam logic [1:0]  STAT_RESET       = 2'h0;
  localparam logic [1:0]  IRQ_EN_RESET     = 2'h0;

  // Events that clear the counters, each a one-cycle pulse
  typedef struct packed {
    logic clrInstr;
    logic sleepInstr;
    logic clockFail;
  } clear_events_s;

  // Device-side configuration straps
  typedef struct packed {
    logic                 cfgWatchdogEnable;
    logic [SEL_WIDTH-1:0] postSel;
    logic                 failSafeMonEnable;
  } strap_config_s;

endpackage : watchdog_pkg

// File: core/watchdog_unit.sv
// Watchdog timer with base divider, postscaler tap and Avalon-MM registers
//
// Register access over Avalon-MM and the address map were left to the implementer.
`timescale 1ns/1ps
`default_nettype none

// Register bus, clear events, straps and time-out outputs
module watchdog_unit #(
  parameter int unsigned BaseCycles = watchdog_pkg::BASE_CYCLES
) (
  input  wire  logic                                core_clk,
  input  wire  logic                                rst_b,
  input  wire  logic [3:0]                          address,
  input  wire  logic                                read,
  input  wire  logic                                write,
  input  wire  logic [3:0]                          byteenable,
  input  wire  logic [31:0]                         writedata,
  output logic       [31:0]                         readdata,
  output logic                                      waitrequest,
  input  wire  watchdog_pkg::clear_events_s         events,
  input  wire  watchdog_pkg::strap_config_s         straps,
  input  wire  logic                                sleeping,
  input  wire  logic [watchdog_pkg::FREQ_WIDTH-1:0] intOscFreqSelect,
  output logic                                      intRcOscOn,
  output logic                                      timeoutReset,
  output logic                                      timeoutWake,
  output logic                                      irq
);

  import watchdog_pkg::*;

  // Tap mask: the postscaler count at which the selected period ends
  // Tap n ends after 2^n base periods, so the mask is 2^n - 1
  // The top tap, 15, shifts one only to bit 15 of the 16-bit mask, so the spare bit never comes into use
  function automatic logic [POST_WIDTH-1:0] tapMask(input logic [SEL_WIDTH-1:0] sel);
    logic [POST_WIDTH:0] one;
    one = {{POST_WIDTH{1'b0}}, 1'b1};
    tapMask = POST_WIDTH'((one << sel) - 1'b1);
  endfunction : tapMask

  // Last base count of one nominal period
  // The parameter lets a bench shorten the period without touching the taps
  localparam logic [31:0] BASE_LAST = 32'(BaseCycles - 1);

  // Base divider and postscaler counts
  logic [31:0]           baseCnt_q;
  logic [31:0]           baseCnt_d;
  logic [POST_WIDTH-1:0] postCnt_q;
  logic [POST_WIDTH-1:0] postCnt_d;

  // Previous frequency select and its arming flag
  logic [FREQ_WIDTH-1:0] freqPrev_q;
  logic [FREQ_WIDTH-1:0] freqPrev_d;
  logic                  freqValid_q;
  logic                  freqValid_d;

  // Software enable, status, interrupt enable and interrupt line
  logic                  swEn_q;
  logic                  swEn_d;
  logic [STAT_WIDTH-1:0] status_q;
  logic [STAT_WIDTH-1:0] status_d;
  logic [STAT_WIDTH-1:0] irqEn_q;
  logic [STAT_WIDTH-1:0] irqEn_d;
  logic                  irq_q;
  logic                  irq_d;

  // Time-out pulses
  logic                  reset_q;
  logic                  reset_d;
  logic                  wake_q;
  logic                  wake_d;

  // Bus handshake and read data
  logic                  ack_q;
  logic                  ack_d;
  logic [31:0]           rdata_q;
  logic [31:0]           rdata_d;

  // Decoded conditions
  logic                  watchdogOn;
  logic                  freqChange;
  logic                  clearAll;
  logic                  baseTick;
  logic                  expire;
  logic                  busReq;
  logic                  busWr;
  logic [STAT_WIDTH-1:0] statSet;
  logic [STAT_WIDTH-1:0] statClr;

  // Enable resolution and event decode
  // The strap enable wins; the software bit only matters when the strap is off
  // A clear in the same cycle as an expiry suppresses that expiry
  always_comb begin
    watchdogOn = straps.cfgWatchdogEnable | swEn_q;
    freqChange = freqValid_q & (intOscFreqSelect != freqPrev_q);
    clearAll   = events.clrInstr | events.sleepInstr
               | freqChange | events.clockFail;
    baseTick   = (baseCnt_q == BASE_LAST);
    expire     = watchdogOn & ~clearAll & baseTick
               & (postCnt_q == tapMask(straps.postSel));
  end

  // Bus decode: the first cycle of a request waits, the second is taken
  // Only byte lane 0 carries register bits, so other lanes alone write nothing
  always_comb begin
    busReq = (read | write) & ~ack_q;
    busWr  = write & ack_q & byteenable[0];
  end

  // The oscillator runs while the watchdog or the clock monitor needs it
  // The failSafeMonEnable strap term means disabling the watchdog never stops the monitor
  assign intRcOscOn = watchdogOn | straps.failSafeMonEnable;

  // Counter next state; a clear event beats a tick in the same cycle
  // Disabled counters sit at zero so a later enable starts a full period
  always_comb begin
    baseCnt_d = baseCnt_q;
    postCnt_d = postCnt_q;
    if (clearAll || !watchdogOn) begin
      baseCnt_d = 32'h0;
      postCnt_d = {POST_WIDTH{1'b0}};
    end else if (baseTick) begin
      baseCnt_d = 32'h0;
      // Expiry restarts the count so a sleeping core is woken once per period
      postCnt_d = expire ? {POST_WIDTH{1'b0}} : POST_WIDTH'(postCnt_q + 1'b1);
    end else begin
      baseCnt_d = baseCnt_q + 32'h1;
    end
  end

  // Counter registers
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      baseCnt_q <= 32'h0;
      postCnt_q <= {POST_WIDTH{1'b0}};
    end else begin
      baseCnt_q <= baseCnt_d;
      postCnt_q <= postCnt_d;
    end
  end

  // Frequency select tracking; the first cycle after reset only loads it
  // Without the arming flag a nonzero select at reset would look like a change
  always_comb begin
    freqPrev_d  = intOscFreqSelect;
    freqValid_d = 1'b1;
  end

  // Frequency select tracking registers
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      freqPrev_q  <= {FREQ_WIDTH{1'b0}};
      freqValid_q <= 1'b0;
    end else begin
      freqPrev_q  <= freqPrev_d;
      freqValid_q <= freqValid_d;
    end
  end

  // Time-out action: reset when awake, wake when sleeping
  // The sleeping level is taken as the core reports it in the expiry cycle
  always_comb begin
    reset_d = expire & ~sleeping;
    wake_d  = expire & sleeping;
  end

  // Time-out pulse registers
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      reset_q <= 1'b0;
      wake_q  <= 1'b0;
    end else begin
      reset_q <= reset_d;
      wake_q  <= wake_d;
    end
  end

  // Registered pulses keep the reset request free of decode glitches
  assign timeoutReset = reset_q;
  assign timeoutWake  = wake_q;

  // Software enable: only bit 0 of the control word is stored
  // Bits 31..1 have no storage, so they read back as zero and writes vanish
  always_comb begin
    swEn_d = swEn_q;
    if (busWr && (address == OFS_CONTROL)) begin
      swEn_d = writedata[CTRL_SW_EN_BIT];
    end
  end

  // Software enable register
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      swEn_q <= SW_EN_RESET;
    end else begin
      swEn_q <= swEn_d;
    end
  end

  // Interrupt enable next state, same layout as the status register
  always_comb begin
    irqEn_d = irqEn_q;
    if (busWr && (address == OFS_IRQ_EN)) begin
      irqEn_d = writedata[STAT_WIDTH-1:0];
    end
  end

  // Interrupt enable register
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      irqEn_q <= IRQ_EN_RESET;
    end else begin
      irqEn_q <= irqEn_d;
    end
  end

  // Status next state; hardware set wins over a software clear in one cycle
  // The interrupt follows the next status, so it rises with the flag itself
  always_comb begin
    statClr = {STAT_WIDTH{1'b0}};
    statSet = {STAT_WIDTH{1'b0}};
    statSet[STAT_TIMEOUT_BIT] = expire;
    statSet[STAT_CLKFAIL_BIT] = events.clockFail;
    if (busWr && (address == OFS_CLEAR)) begin
      statClr = writedata[STAT_WIDTH-1:0];
    end
    status_d = (status_q & ~statClr) | statSet;
    irq_d    = |(status_d & irqEn_d);
  end

  // Status and interrupt registers
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      status_q <= STAT_RESET;
      irq_q    <= 1'b0;
    end else begin
      status_q <= status_d;
      irq_q    <= irq_d;
    end
  end

  // Read data is captured on the first cycle of a read request
  // That costs one wait state but keeps the read path out of the bus timing
  always_comb begin
    rdata_d = 32'h0;
    if (read && !ack_q) begin
      unique case (address)
        OFS_CONTROL: rdata_d[CTRL_SW_EN_BIT] = swEn_q;
        OFS_STATUS:  rdata_d[STAT_WIDTH-1:0] = status_q;
        OFS_IRQ_EN:  rdata_d[STAT_WIDTH-1:0] = irqEn_q;
        default:     rdata_d = 32'h0;
      endcase
    end else begin
      rdata_d = rdata_q;
    end
    ack_d = busReq;
  end

  // Bus handshake registers
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      ack_q   <= 1'b0;
      rdata_q <= 32'h0;
    end else begin
      ack_q   <= ack_d;
      rdata_q <= rdata_d;
    end
  end

  // One wait state per access keeps read data registered
  // A master that holds its request past the answer starts a new access
  assign waitrequest = (read | write) & ~ack_q;
  assign readdata    = rdata_q;
  assign irq         = irq_q;

endmodule : watchdog_unit
`default_nettype wire

// File: tb/watchdog_unit_monitor.sv
// Port-level assertions of the watchdog unit
`timescale 1ns/1ps
`default_nettype none
module watchdog_unit_monitor #(parameter int unsigned BaseCycles = watchdog_pkg::BASE_CYCLES) (
  input wire logic                               core_clk,
  input wire logic                               rst_b,
  input wire logic [3:0]                         address,
  input wire logic                               read,
  input wire logic                               write,
  input wire logic [31:0]                        readdata,
  input wire logic                               waitrequest,
  input wire watchdog_pkg::clear_events_s        events,
  input wire watchdog_pkg::strap_config_s        straps,
  input wire logic                               sleeping,
  input wire logic [watchdog_pkg::FREQ_WIDTH-1:0] intOscFreqSelect,
  input wire logic                               intRcOscOn,
  input wire logic                               timeoutReset,
  input wire logic                               timeoutWake
);
  import watchdog_pkg::*;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  // Any expiry, reset or wake; a cleared count needs a full base period
  wire logic expiry = timeoutReset | timeoutWake;
  property p_osc; straps.cfgWatchdogEnable | straps.failSafeMonEnable |-> intRcOscOn; endproperty
  a_osc: assert property (p_osc) else $error("oscillator request missing");
  property p_rst; timeoutReset |-> !$past(sleeping) && !timeoutWake; endproperty
  a_rst: assert property (p_rst) else $error("reset while asleep");
  property p_wake; timeoutWake |-> $past(sleeping); endproperty
  a_wake: assert property (p_wake) else $error("wake while awake");
  property p_gap; expiry |=> !expiry [*3]; endproperty
  a_gap: assert property (p_gap) else $error("expiries too close");
  property p_clr; events.clrInstr | events.sleepInstr |-> ##1 !expiry [*3]; endproperty
  a_clr: assert property (p_clr) else $error("expiry after clear");
  property p_fail; events.clockFail |-> ##1 !expiry [*3]; endproperty
  a_fail: assert property (p_fail) else $error("expiry after clock failure");
  property p_freq; $changed(intOscFreqSelect) |-> ##1 !expiry [*3]; endproperty
  a_freq: assert property (p_freq) else $error("expiry after freq change");
  property p_wait; (read | write) & waitrequest |=> !waitrequest; endproperty
  a_wait: assert property (p_wait) else $error("wait state too long");
  property p_ctl; read & !waitrequest & (address == OFS_CONTROL) |-> readdata[31:1] == 31'h0; endproperty
  a_ctl: assert property (p_ctl) else $error("control upper bits set");
  c_rst: cover property (timeoutReset);
  c_wake: cover property (timeoutWake);
  c_freq: cover property ($changed(intOscFreqSelect));
endmodule : watchdog_unit_monitor
bind watchdog_unit watchdog_unit_monitor #(.BaseCycles(BaseCycles)) u_mon (.core_clk(core_clk), .rst_b(rst_b),
  .address(address), .read(read), .write(write), .readdata(readdata), .waitrequest(waitrequest),
  .events(events), .straps(straps), .sleeping(sleeping), .intOscFreqSelect(intOscFreqSelect),
  .intRcOscOn(intRcOscOn), .timeoutReset(timeoutReset), .timeoutWake(timeoutWake));
`default_nettype wire

// File: tb/test_watchdog_unit.sv
// Self-checking bench of the watchdog unit
`timescale 1ns/1ps
`default_nettype none
module test_watchdog_unit;
  import watchdog_pkg::*;
  localparam int unsigned Base = 4;  // Short base period keeps taps fast
  logic        core_clk = 1'b0, rst_b = 1'b0, read = 1'b0, write = 1'b0, sleeping = 1'b0;
  logic [3:0]  address = 4'h0, be = 4'hF;
  logic [31:0] writedata = 32'h0, readdata, rd, wd;
  logic [2:0]  freq = 3'h0;
  logic        waitrequest, intRcOscOn, timeoutReset, timeoutWake, irq, wk;
  clear_events_s evts = '0;
  strap_config_s cfg = '0;
  int          errCount = 0, nTests = 0, cyc = 0, n;
  integer      seed = 32'h8B38;
  watchdog_unit #(.BaseCycles(Base)) u_dut (.core_clk(core_clk), .rst_b(rst_b), .address(address),
    .read(read), .write(write), .byteenable(be), .writedata(writedata), .readdata(readdata),
    .waitrequest(waitrequest), .events(evts), .straps(cfg), .sleeping(sleeping), .intOscFreqSelect(freq),
    .intRcOscOn(intRcOscOn), .timeoutReset(timeoutReset), .timeoutWake(timeoutWake), .irq(irq));
  // Clock and hang guard
  always #4 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      errCount++;
      results();
    end
  end
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    nTests++;
    if (g !== e) begin
      errCount++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  // Request held until waitrequest is sampled low at a rising edge
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge core_clk);
    address <= a;
    write <= w;
    read <= !w;
    writedata <= d;
    do @(posedge core_clk); while (waitrequest !== 1'b0);
    rd = readdata;
    write <= 1'b0;
    read <= 1'b0;
  endtask : bus
  // k picks clear, sleep, clock failure or a freq select change
  task automatic pulse(input int k);
    @(posedge core_clk);
    if (k < 3) evts <= clear_events_s'(3'b100 >> k);
    else freq <= freq + 3'h1;
    @(posedge core_clk);
    evts <= '0;
  endtask : pulse
  task automatic expire();
    n = 0;
    do begin
      @(negedge core_clk);
      n++;
    end while (timeoutReset !== 1'b1 && timeoutWake !== 1'b1 && n < 300);
    wk = timeoutWake;
    @(posedge core_clk);
  endtask : expire
  task automatic timed(input int k, input int sel);
    pulse(k);
    expire();
    chk("period", 1, 32'(n >= (Base << sel) && n <= (Base << sel) + 2));
  endtask : timed
  task automatic results();
    $display("checks %0d mismatches %0d", nTests, errCount);
    if (errCount == 0 && nTests > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : results
  // Main sequence
  initial begin
    repeat (4) @(posedge core_clk);
    rst_b <= 1'b1;
    bus(0, OFS_CLEAR, 0);
    chk("unmapped", 0, rd);
    for (int i = 0; i < 3; i++) begin
      wd = $random(seed);
      bus(1, OFS_CONTROL, wd);
      bus(0, OFS_CONTROL, 0);
      chk("control", {31'h0, wd[0]}, rd);
    end
    bus(1, OFS_CONTROL, 0);
    be <= 4'hE;
    bus(1, OFS_CONTROL, 1);
    be <= 4'hF;
    bus(0, OFS_CONTROL, 0);
    chk("byte lane", 0, rd);
    $display("bus done");
    expire();
    chk("idle", 300, n);
    chk("osc off", 0, intRcOscOn);
    cfg.failSafeMonEnable <= 1'b1;
    @(negedge core_clk);
    chk("osc monitor", 1, intRcOscOn);
    @(posedge core_clk);
    cfg.cfgWatchdogEnable <= 1'b1;
    for (int s = 0; s < 5; s++) begin
      cfg.postSel <= 4'(s);
      timed(0, s);
    end
    $display("taps done");
    cfg.postSel <= 4'h2;
    for (int k = 0; k < 4; k++) begin
      sleeping <= (k == 1);
      pulse(0);
      repeat (10) @(negedge core_clk);
      timed(k, 2);
      chk("wake", 32'(k == 1), 32'(wk));
    end
    $display("events done");
    sleeping <= 1'b0;
    bus(1, OFS_IRQ_EN, 1);
    @(negedge core_clk);
    chk("irq", 1, irq);
    bus(0, OFS_STATUS, 0);
    chk("status", 3, rd);
    cfg.cfgWatchdogEnable <= 1'b0;
    bus(1, OFS_CLEAR, 3);
    bus(0, OFS_STATUS, 0);
    chk("cleared", 0, rd);
    @(negedge core_clk);
    chk("irq off", 0, irq);
    bus(1, OFS_CONTROL, 1);
    timed(0, 2);
    $display("enable done");
    results();
  end
endmodule : test_watchdog_unit
`default_nettype wire
